// File: hw/tcp_pkg.sv
// tcp_pkg: constants and types shared by both ends of the two-wire
// control port link.
// assumes: compiled before the link interface and both end modules.
package tcp_pkg;

    // device address bits 7..2; bit 1 comes from the address-select strap
    localparam logic [5:0] SLV_ADDR_FIXED = 6'h26;
    // highest implemented register address unless the top overrides it
    localparam logic [7:0] REG_ADDR_MAX_DEF = 8'hF0;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // bit slots inside one byte frame: 0..7 data, 8 acknowledge
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic DIR_READ = 1'b1;

    // host clock generation: one quarter of a link clock period
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCL_QTR_NS = 100;
    localparam int SCL_QTR_CYC =
        (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] QTR_LAST = 8'(SCL_QTR_CYC - 1);

    typedef enum logic [2:0] {
        DS_IDLE, DS_DEVADDR, DS_REGADDR, DS_WDATA, DS_RDATA, DS_SKIP
    } tcp_dev_st_t;

    typedef enum logic [1:0] {
        HS_IDLE, HS_START, HS_STOP, HS_BIT
    } tcp_host_st_t;

    typedef enum logic [1:0] {
        OP_START, OP_STOP, OP_WRITE, OP_READ
    } tcp_op_t;

endpackage : tcp_pkg

// File: hw/tcp_link_if.sv
// tcp_link_if: the two-wire link between bus master and control port.
// assumes: open-drain data line with a pull-up; only the master drives
// the clock line.
`timescale 1ns/1ps
interface tcp_link_if;
    logic scl;
    logic m_sda_out;
    logic m_sda_oe;
    logic s_sda_out;
    logic s_sda_oe;
    logic sda;

    // wired-and with pull-up: released line reads high
    assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

    modport dev (
        input scl,
        input sda,
        output s_sda_out,
        output s_sda_oe
    );

    modport host (
        output scl,
        input sda,
        output m_sda_out,
        output m_sda_oe
    );
endinterface : tcp_link_if

// File: hw/tcp_dev_port.sv
// tcp_dev_port: slave end of the two-wire control port.
// assumes: link clock comes from the master; system side owns a
// register file with a combinational read port on rd_addr_out.
//
// Overview of operation
// - data falling while clock high is start
// - data rising while clock high is stop
// - data stable in clock high, else framing
// - first byte: seven address bits, direction
// - acknowledge own address in ninth slot
// - address fixed, low bit from strap pin
// - bytes go most significant bit first
// - refused byte leaves data line released
// - master not-acknowledge ends read data
// - write's second byte loads register pointer
// - pointer advances after each written byte
// - pointer saturates at highest register address
// - refuse pointer above highest register address
// - read starts at previously stored pointer
// - pointer advances at the first bit of each read byte
// - repeated start begins a new address phase
`timescale 1ns/1ps
module tcp_dev_port
    import tcp_pkg::*;
#(
    parameter logic [7:0] MAX_REG_ADDR = REG_ADDR_MAX_DEF
) (
    // system clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // strap
    input wire logic addr_select_pin_in,
    // register write strobe
    output logic wr_valid_out,
    output logic [7:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    // register read port
    output logic [7:0] rd_addr_out,
    input wire logic [7:0] rd_data_in,
    // serial link
    tcp_link_if.dev link
);

    // ---------------- framing, clocked by the data line ----------------
    logic start_tgl_r;
    logic stop_tgl_r;

    // framing flops sit on the data line itself because the link clock
    // stands still while start and stop happen
    always_ff @(negedge link.sda or negedge resetn_in) begin
        if (!resetn_in) begin
            start_tgl_r <= 1'b0;
        end else if (link.scl) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    always_ff @(posedge link.sda or negedge resetn_in) begin
        if (!resetn_in) begin
            stop_tgl_r <= 1'b0;
        end else if (link.scl) begin
            stop_tgl_r <= ~stop_tgl_r;
        end
    end

    // ---------------- link clock domain ----------------
    tcp_dev_st_t st_r;
    logic start_seen_r;
    logic stop_seen_r;
    logic [3:0] cnt_r;
    logic [6:0] shift_r;
    logic ack_r;
    logic sel_meta_r;
    logic sel_r;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic ptr_tgl_r;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic wr_tgl_r;
    logic ack_meta_r;
    logic ack_sync_r;
    logic ack_prev_r;
    logic [7:0] rd_word_r;
    logic sda_lo_r;
    logic [7:0] tx_r;
    logic [7:0] rd_hold_r;
    logic rd_ack_tgl_r;

    logic start_pend;
    logic stop_pend;
    logic bit_ok;
    logic byte_done;
    logic [7:0] byte_w;
    logic addr_hit;
    logic base_ok;

    // toggles were set half a link clock or more before the next edge
    assign start_pend = start_tgl_r ^ start_seen_r;
    assign stop_pend = stop_tgl_r ^ stop_seen_r;
    assign bit_ok = ~start_pend & ~stop_pend & (st_r != DS_IDLE);
    assign byte_done = bit_ok & (cnt_r == LAST_BIT);
    assign byte_w = {shift_r, link.sda};
    assign addr_hit = (byte_w[7:1] == {SLV_ADDR_FIXED, sel_r});
    assign base_ok = (byte_w <= MAX_REG_ADDR);
    assign ptr_nxt = (ptr_r == MAX_REG_ADDR) ? ptr_r
                                             : ptr_r + 8'h01;

    // strap is static but still passes two flops before use
    always_ff @(posedge link.scl or negedge resetn_in) begin
        if (!resetn_in) begin
            sel_meta_r <= 1'b0;
            sel_r <= 1'b0;
        end else begin
            sel_meta_r <= addr_select_pin_in;
            sel_r <= sel_meta_r;
        end
    end

    // protocol state, sampled on the rising link clock
    always_ff @(posedge link.scl or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= DS_IDLE;
            start_seen_r <= 1'b0;
            stop_seen_r <= 1'b0;
            cnt_r <= 4'h0;
            shift_r <= 7'h00;
            ack_r <= 1'b0;
        end else begin
            start_seen_r <= start_tgl_r;
            stop_seen_r <= stop_tgl_r;
            ack_r <= 1'b0;
            if (start_pend) begin
                st_r <= DS_DEVADDR;
                cnt_r <= 4'h1;
                shift_r <= {6'h00, link.sda};
            end else if (stop_pend) begin
                st_r <= DS_IDLE;
                cnt_r <= 4'h0;
            end else if (st_r != DS_IDLE) begin
                if (cnt_r == ACK_SLOT) begin
                    cnt_r <= 4'h0;
                    if (st_r == DS_RDATA && link.sda) begin
                        st_r <= DS_SKIP;
                    end
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                    shift_r <= byte_w[6:0];
                    if (cnt_r == LAST_BIT) begin
                        case (st_r)
                            DS_DEVADDR: begin
                                if (addr_hit) begin
                                    ack_r <= 1'b1;
                                    st_r <= (byte_w[0] == DIR_READ) ?
                                        DS_RDATA : DS_REGADDR;
                                end else begin
                                    st_r <= DS_SKIP;
                                end
                            end
                            DS_REGADDR: begin
                                ack_r <= base_ok;
                                st_r <= base_ok ? DS_WDATA : DS_SKIP;
                            end
                            DS_WDATA: begin
                                ack_r <= 1'b1;
                            end
                            default: begin
                                ack_r <= 1'b0;
                            end
                        endcase
                    end
                end
            end
        end
    end

    // register pointer; every change asks the system side for a prefetch
    always_ff @(posedge link.scl or negedge resetn_in) begin
        if (!resetn_in) begin
            ptr_r <= PTR_RST;
            ptr_tgl_r <= 1'b0;
        end else if (byte_done && st_r == DS_REGADDR && base_ok) begin
            ptr_r <= byte_w;
            ptr_tgl_r <= ~ptr_tgl_r;
        end else if (byte_done && st_r == DS_WDATA) begin
            ptr_r <= ptr_nxt;
            ptr_tgl_r <= ~ptr_tgl_r;
        end else if (bit_ok && st_r == DS_RDATA && cnt_r == 4'h0) begin
            // advancing at the first bit leaves eight clocks to prefetch
            ptr_r <= ptr_nxt;
            ptr_tgl_r <= ~ptr_tgl_r;
        end
    end

    // written byte is held for a whole byte time while it crosses
    always_ff @(posedge link.scl or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_addr_r <= PTR_RST;
            wr_data_r <= BYTE_RST;
            wr_tgl_r <= 1'b0;
        end else if (byte_done && st_r == DS_WDATA) begin
            wr_addr_r <= ptr_r;
            wr_data_r <= byte_w;
            wr_tgl_r <= ~wr_tgl_r;
        end
    end

    // prefetched read word arrives by toggle handshake
    always_ff @(posedge link.scl or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_meta_r <= 1'b0;
            ack_sync_r <= 1'b0;
            ack_prev_r <= 1'b0;
            rd_word_r <= BYTE_RST;
        end else begin
            ack_meta_r <= rd_ack_tgl_r;
            ack_sync_r <= ack_meta_r;
            ack_prev_r <= ack_sync_r;
            if (ack_sync_r ^ ack_prev_r) begin
                rd_word_r <= rd_hold_r;
            end
        end
    end

    // data line is only ever changed on the falling link clock
    always_ff @(negedge link.scl or negedge resetn_in) begin
        if (!resetn_in) begin
            sda_lo_r <= 1'b0;
            tx_r <= BYTE_RST;
        end else if (start_pend || stop_pend) begin
            sda_lo_r <= 1'b0;
        end else if (cnt_r == ACK_SLOT) begin
            sda_lo_r <= ack_r;
        end else if (st_r == DS_RDATA) begin
            if (cnt_r == 4'h0) begin
                sda_lo_r <= ~rd_word_r[7];
                tx_r <= {rd_word_r[6:0], 1'b0};
            end else begin
                sda_lo_r <= ~tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end else begin
            sda_lo_r <= 1'b0;
        end
    end

    assign link.s_sda_out = 1'b0;
    assign link.s_sda_oe = sda_lo_r;

    // ---------------- system clock domain ----------------
    logic wr_meta_r;
    logic wr_sync_r;
    logic wr_prev_r;
    logic ptr_meta_r;
    logic ptr_sync_r;
    logic ptr_prev_r;
    logic fetch_r;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_meta_r <= 1'b0;
            wr_sync_r <= 1'b0;
            wr_prev_r <= 1'b0;
            wr_valid_out <= 1'b0;
            wr_addr_out <= PTR_RST;
            wr_data_out <= BYTE_RST;
        end else begin
            wr_meta_r <= wr_tgl_r;
            wr_sync_r <= wr_meta_r;
            wr_prev_r <= wr_sync_r;
            wr_valid_out <= wr_sync_r ^ wr_prev_r;
            if (wr_sync_r ^ wr_prev_r) begin
                wr_addr_out <= wr_addr_r;
                wr_data_out <= wr_data_r;
            end
        end
    end

    // read prefetch: present pointer, take data a cycle later, answer
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ptr_meta_r <= 1'b0;
            ptr_sync_r <= 1'b0;
            ptr_prev_r <= 1'b0;
            fetch_r <= 1'b0;
            rd_addr_out <= PTR_RST;
            rd_hold_r <= BYTE_RST;
            rd_ack_tgl_r <= 1'b0;
        end else begin
            ptr_meta_r <= ptr_tgl_r;
            ptr_sync_r <= ptr_meta_r;
            ptr_prev_r <= ptr_sync_r;
            fetch_r <= ptr_sync_r ^ ptr_prev_r;
            if (ptr_sync_r ^ ptr_prev_r) begin
                rd_addr_out <= ptr_r;
            end
            if (fetch_r) begin
                rd_hold_r <= rd_data_in;
                rd_ack_tgl_r <= ~rd_ack_tgl_r;
            end
        end
    end

endmodule : tcp_dev_port

// File: hw/tcp_host_port.sv
// tcp_host_port: bus master end of the two-wire control port.
// assumes: user issues start, byte and stop commands in legal order;
// the link clock is made here by dividing the system clock.
`timescale 1ns/1ps
module tcp_host_port
    import tcp_pkg::*;
(
    // system clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // command
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire tcp_op_t cmd_op_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic cmd_nack_in,
    // answer
    output logic done_out,
    output logic [7:0] rd_data_out,
    output logic ack_out,
    // serial link
    tcp_link_if.host link
);

    tcp_host_st_t st_r;
    tcp_op_t op_r;
    logic [7:0] qcnt_r;
    logic [1:0] ph_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic nack_r;
    logic scl_r;
    logic sda_r;
    logic sda_meta_r;
    logic sda_sync_r;
    logic tick;
    logic bit_val;

    assign tick = (qcnt_r == QTR_LAST);
    assign cmd_ready_out = (st_r == HS_IDLE);

    // value put on the line in this bit slot
    always_comb begin
        bit_val = 1'b1;
        if (bit_r == ACK_SLOT) begin
            bit_val = (op_r == OP_READ) ? nack_r : 1'b1;
        end else if (op_r == OP_WRITE) begin
            bit_val = sh_r[7];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sda_meta_r <= 1'b1;
            sda_sync_r <= 1'b1;
        end else begin
            sda_meta_r <= link.sda;
            sda_sync_r <= sda_meta_r;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            qcnt_r <= 8'h00;
        end else if (st_r == HS_IDLE || tick) begin
            qcnt_r <= 8'h00;
        end else begin
            qcnt_r <= qcnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= HS_IDLE;
            op_r <= OP_STOP;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= BYTE_RST;
            nack_r <= 1'b0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            done_out <= 1'b0;
            rd_data_out <= BYTE_RST;
            ack_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (st_r == HS_IDLE) begin
                if (cmd_valid_in) begin
                    op_r <= cmd_op_in;
                    sh_r <= cmd_data_in;
                    nack_r <= cmd_nack_in;
                    ph_r <= 2'h0;
                    bit_r <= 4'h0;
                    case (cmd_op_in)
                        OP_START: st_r <= HS_START;
                        OP_STOP: st_r <= HS_STOP;
                        default: st_r <= HS_BIT;
                    endcase
                end
            end else if (tick) begin
                ph_r <= ph_r + 2'h1;
                case (st_r)
                    HS_START: begin
                        case (ph_r)
                            2'h0: sda_r <= 1'b1;
                            2'h1: scl_r <= 1'b1;
                            2'h2: sda_r <= 1'b0;
                            default: begin
                                scl_r <= 1'b0;
                                st_r <= HS_IDLE;
                                done_out <= 1'b1;
                            end
                        endcase
                    end
                    HS_STOP: begin
                        case (ph_r)
                            2'h0: sda_r <= 1'b0;
                            2'h1: scl_r <= 1'b1;
                            2'h2: sda_r <= 1'b1;
                            default: begin
                                st_r <= HS_IDLE;
                                done_out <= 1'b1;
                            end
                        endcase
                    end
                    HS_BIT: begin
                        case (ph_r)
                            2'h0: sda_r <= bit_val;
                            2'h1: scl_r <= 1'b1;
                            2'h2: scl_r <= 1'b1;
                            default: begin
                                scl_r <= 1'b0;
                                bit_r <= bit_r + 4'h1;
                                if (bit_r == ACK_SLOT) begin
                                    ack_out <= ~sda_sync_r;
                                    if (op_r == OP_READ) begin
                                        rd_data_out <= sh_r;
                                    end
                                    st_r <= HS_IDLE;
                                    done_out <= 1'b1;
                                end else begin
                                    sh_r <= {sh_r[6:0], sda_sync_r};
                                end
                            end
                        endcase
                    end
                    default: st_r <= HS_IDLE;
                endcase
            end
        end
    end

    assign link.scl = scl_r;
    assign link.m_sda_out = 1'b0;
    assign link.m_sda_oe = ~sda_r;

endmodule : tcp_host_port

// File: sim/tcp_link_monitor.sv
// tcp_link_monitor: protocol checks on the shared two-wire link.
// assumes: sampled on the system clock, many times faster than scl;
// instantiated beside the link interface by the bench top.
`timescale 1ns/1ps
module tcp_link_monitor
    import tcp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // link signals
    input wire logic scl,
    input wire logic m_sda_out,
    input wire logic m_sda_oe,
    input wire logic s_sda_out,
    input wire logic s_sda_oe,
    input wire logic sda
);
    logic scl_q_r;
    logic sda_q_r;
    logic first_r;
    logic rd_r;
    logic quiet_r;
    logic [3:0] cnt_r;
    wire start_w = scl && scl_q_r && sda_q_r && !sda;
    wire stop_w = scl && scl_q_r && !sda_q_r && sda;
    wire rise_w = scl && !scl_q_r;

    default clocking mon_cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl;
            sda_q_r <= sda;
        end
    end

    // rising clock edges in the current byte; framing edges restart it
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r <= 4'h0;
            first_r <= 1'b0;
        end else if (start_w || stop_w) begin
            cnt_r <= 4'h0;
            first_r <= start_w;
        end else if (rise_w) begin
            cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
            if (cnt_r == 4'h9) begin
                first_r <= 1'b0;
            end
        end
    end

    // direction of the frame and whether an ack slot went unanswered
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_r <= 1'b0;
            quiet_r <= 1'b0;
        end else if (start_w || stop_w) begin
            rd_r <= 1'b0;
            quiet_r <= 1'b0;
        end else if (rise_w) begin
            if (first_r && cnt_r == 4'h7) begin
                rd_r <= (sda == DIR_READ);
            end
            if (cnt_r == 4'h8 && sda) begin
                quiet_r <= 1'b1;
            end
        end
    end

    AST_DEV_EDGE: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("device data moved while clock high");
    AST_HIGH_FRAME: assert property (
        scl && $past(scl) && $changed(sda)
        |-> $changed(m_sda_oe) && $stable(s_sda_oe))
        else $error("data edge in clock high not made by master");
    AST_FRAME_BOUNDARY: assert property (
        scl && $past(scl) && $changed(sda) |-> cnt_r <= 4'h1)
        else $error("start or stop inside a byte");
    AST_ADDR_NO_DRIVE: assert property (
        first_r && cnt_r < 4'h8 |-> !s_sda_oe)
        else $error("device drove during the address bits");
    AST_RD_ACK_FREE: assert property (
        rd_r && !first_r && cnt_r == 4'h9 && scl |-> !s_sda_oe)
        else $error("device held the master ack slot");
    AST_WR_QUIET: assert property (
        quiet_r && !rd_r |-> !s_sda_oe)
        else $error("device drove after a refused byte");
    AST_RD_QUIET: assert property (quiet_r && rd_r |-> !s_sda_oe)
        else $error("device drove after master not-ack");
    AST_WR_ACK_END: assert property (
        $fell(scl) && cnt_r == 4'h9 && !rd_r |-> !s_sda_oe)
        else $error("device ack not released after ninth pulse");

    cover property (start_w && cnt_r == 4'h1);
    cover property (rise_w && cnt_r == 4'h8 && !sda && !rd_r);
    cover property ($rose(quiet_r) && rd_r);
    cover property (stop_w);
endmodule : tcp_link_monitor

// File: sim/tb.sv
// tb: both link ends joined back to back, driven from the host command
// port, with a stand-in register file on the device side.
// assumes: tcp_pkg, tcp_link_if, both ends and the monitor are compiled.
`timescale 1ns/1ps
module tb;
    import tcp_pkg::*;
    localparam logic [7:0] MAX_A = 8'h3F;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b1;
    logic cmd_valid_in = 1'b0;
    tcp_op_t cmd_op_in = OP_START;
    logic [7:0] cmd_data_in = 8'h00;
    logic cmd_nack_in = 1'b0;
    logic sel_in = 1'b0;
    logic cmd_ready, done, ack, wr_valid;
    logic [7:0] rd_byte, rd_addr, rd_data, wr_addr, wr_data;
    logic [8:0] wire_sh = 9'h000;
    logic [15:0] wlog[$];
    int n_errors = 0;
    int check_count = 0;

    tcp_link_if link ();
    tcp_dev_port #(.MAX_REG_ADDR(MAX_A)) tcp_dev_port_inst (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .addr_select_pin_in(sel_in), .wr_valid_out(wr_valid),
        .wr_addr_out(wr_addr), .wr_data_out(wr_data),
        .rd_addr_out(rd_addr), .rd_data_in(rd_data), .link(link));
    tcp_host_port tcp_host_port_inst (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready),
        .cmd_op_in(cmd_op_in), .cmd_data_in(cmd_data_in),
        .cmd_nack_in(cmd_nack_in), .done_out(done),
        .rd_data_out(rd_byte), .ack_out(ack), .link(link));
    tcp_link_monitor tcp_link_monitor_inst (
        .clk_in(clk_in), .resetn_in(resetn_in), .scl(link.scl),
        .m_sda_out(link.m_sda_out), .m_sda_oe(link.m_sda_oe),
        .s_sda_out(link.s_sda_out), .s_sda_oe(link.s_sda_oe),
        .sda(link.sda));

    always #10 clk_in = ~clk_in;
    // register content is a fixed function of its address
    assign rd_data = rd_addr ^ 8'hA5;
    always @(posedge clk_in) begin
        if (wr_valid === 1'b1) begin
            wlog.push_back({wr_addr, wr_data});
        end
    end
    // bits in the order they crossed the wire, ack slot last
    always @(posedge link.scl) begin
        wire_sh <= {wire_sh[7:0], link.sda};
    end

    task automatic final_report;
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] ea(logic [7:0] b, int i);
        logic [8:0] s;
        s = 9'(b) + 9'(i);
        return (s > 9'(MAX_A)) ? MAX_A : s[7:0];
    endfunction : ea

    function automatic logic [7:0] daddr(logic rd);
        return {SLV_ADDR_FIXED, sel_in, rd};
    endfunction : daddr

    // hold the command until it is taken, then wait for its done pulse
    task automatic cmd(tcp_op_t op, logic [7:0] d, logic nk);
        int i;
        cmd_op_in = op;
        cmd_data_in = d;
        cmd_nack_in = nk;
        cmd_valid_in = 1'b1;
        for (i = 0; i < 10 && cmd_ready !== 1'b1; i++) begin
            @(posedge clk_in);
            #1;
        end
        if (cmd_ready !== 1'b1) begin
            n_errors++;
            final_report();
        end
        @(posedge clk_in);
        #1;
        cmd_valid_in = 1'b0;
        for (i = 0; i < 400; i++) begin
            @(posedge clk_in);
            #1;
            if (done === 1'b1) break;
        end
        if (i == 400) begin
            n_errors++;
            final_report();
        end
    endtask : cmd

    task automatic wbyte(logic [7:0] d, logic exp_ack);
        cmd(OP_WRITE, d, 1'b0);
        check("write ack", 8'(ack), 8'(exp_ack));
        check("wire byte", wire_sh[8:1], d);
        check("wire ack slot", 8'(wire_sh[0]), 8'(!exp_ack));
    endtask : wbyte

    task automatic rbyte(logic [7:0] exp, logic nk);
        cmd(OP_READ, 8'h00, nk);
        check("read data", rd_byte, exp);
        check("wire read byte", wire_sh[8:1], exp);
        check("wire master ack", 8'(wire_sh[0]), 8'(nk));
    endtask : rbyte

    task automatic t_write(logic [7:0] base, int n);
        int i;
        wlog.delete();
        cmd(OP_START, 8'h00, 1'b0);
        wbyte(daddr(1'b0), 1'b1);
        wbyte(base, 1'b1);
        for (i = 0; i < n; i++) begin
            wbyte(8'(i) ^ 8'hC3, 1'b1);
        end
        cmd(OP_STOP, 8'h00, 1'b0);
        check("write count", 8'(wlog.size()), 8'(n));
        for (i = 0; i < n && i < wlog.size(); i++) begin
            check("write addr", wlog[i][15:8], ea(base, i));
            check("write data", wlog[i][7:0], 8'(i) ^ 8'hC3);
        end
    endtask : t_write

    // foreign addresses: wrong strap bit, then wrong fixed bit
    task automatic t_strap;
        wlog.delete();
        cmd(OP_START, 8'h00, 1'b0);
        wbyte({SLV_ADDR_FIXED, !sel_in, 1'b0}, 1'b0);
        wbyte(8'h01, 1'b0);
        cmd(OP_START, 8'h00, 1'b0);
        wbyte({SLV_ADDR_FIXED ^ 6'h01, sel_in, 1'b0}, 1'b0);
        cmd(OP_STOP, 8'h00, 1'b0);
        check("foreign writes", 8'(wlog.size()), 8'h00);
    endtask : t_strap

    task automatic t_bad_base;
        wlog.delete();
        cmd(OP_START, 8'h00, 1'b0);
        wbyte(daddr(1'b0), 1'b1);
        wbyte(MAX_A + 8'h01, 1'b0);
        wbyte(8'h5A, 1'b0);
        cmd(OP_STOP, 8'h00, 1'b0);
        check("refused writes", 8'(wlog.size()), 8'h00);
    endtask : t_bad_base

    task automatic t_read(logic [7:0] base, int n);
        int i;
        wlog.delete();
        cmd(OP_START, 8'h00, 1'b0);
        wbyte(daddr(1'b0), 1'b1);
        wbyte(base, 1'b1);
        cmd(OP_START, 8'h00, 1'b0);
        wbyte(daddr(DIR_READ), 1'b1);
        for (i = 0; i < n; i++) begin
            rbyte(ea(base, i) ^ 8'hA5, 1'(i == n - 1));
        end
        cmd(OP_STOP, 8'h00, 1'b0);
        check("read side writes", 8'(wlog.size()), 8'h00);
    endtask : t_read

    initial begin
        // a true falling edge: link-side flops see no clock before a start
        #1;
        resetn_in = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        resetn_in = 1'b1;
        check("idle scl", 8'(link.scl), 8'h01);
        check("idle sda", 8'(link.sda), 8'h01);
        for (int s = 0; s < 2; s++) begin
            sel_in = 1'(s);
            t_strap();
            t_write(8'h10, 4);
        end
        t_write(MAX_A - 8'h01, 3);
        t_bad_base();
        t_read(8'h20, 4);
        t_read(MAX_A - 8'h01, 3);
        final_report();
    end
endmodule : tb
